// ---- rtl/lstu_defines.vh ----
// Constants for the load/store timing unit: op codes, base costs and penalties.
// Assumes one core clock; all costs are in core clock cycles.
// Notes on behaviour
// - Immediate-offset store_word issues in one cycle; data write overlaps the next instruction.
// - Store to a full or disabled store buffer holds the next instruction until done.
// - Stalled buffered store delays only a later load or store issued before it drains.
// - Load into program_counter blocks: two load plus three refill, five cycles minimum.
// - Address using previous data-processing result costs one extra cycle; no forwarding.
// - Program-counter-relative load_word adds one cycle when fetch contends for the bus.
// - Table branches block: two load, one add, three refill, six cycles minimum.
// - Independent load_word then load or store removes one cycle from the second.
// - Store pipelines only behind a load or an exclusive store; nothing pipelines behind a plain store.
// - Exclusive load and store pipeline exactly like ordinary load_word.
// - Load_pair and store_pair never pipeline with neighbours; three cycles unstalled.
// - Load and store multiple cost element count plus one; no pipelining with neighbours.
// - Resumed multiple transfer adds one or two cycles to its first element.
// - Unaligned accesses split into pieces, adding one or two cycles; stalls extend them.
// - Bus matrix arbitrates core and debug, core always granted first.
// - With zero-wait memory, debug accesses never disturb core timing.
// - Unaligned access is one transaction from the core's view.
// - Buffered stores use a one-entry buffer; later accesses stall until it drains.
// - Buffer is occupied only if the bus waits the buffered store's data phase.
`ifndef LSTU_DEFINES_VH
`define LSTU_DEFINES_VH
// Op classes on issue_op
`define LSTU_OP_OTHER 3'h0
`define LSTU_OP_LOAD 3'h1
`define LSTU_OP_STORE 3'h2
`define LSTU_OP_LOAD_EXCL 3'h3
`define LSTU_OP_STORE_EXCL 3'h4
`define LSTU_OP_PAIR 3'h5
`define LSTU_OP_MULTIPLE 3'h6
`define LSTU_OP_TABLE_BR 3'h7
// Access sizes on issue_size
`define LSTU_SIZE_BYTE 2'h0
`define LSTU_SIZE_HALF 2'h1
`define LSTU_SIZE_WORD 2'h2
// Base costs in cycles
`define LSTU_CYC_LOAD 6'h02
`define LSTU_CYC_STORE_IMM 6'h01
`define LSTU_CYC_STORE_REG 6'h02
`define LSTU_CYC_LOAD_PC 6'h05
`define LSTU_CYC_TABLE_BR 6'h06
`define LSTU_CYC_PAIR 6'h03
`define LSTU_CYC_MULT_FIRST 6'h01
`define LSTU_CYC_PIPE_SAVE 6'h01
`define LSTU_CYC_DEP 6'h01
`define LSTU_CYC_FETCH 6'h01
`define LSTU_PC_REG 4'hf
`endif

// ---- rtl/lstu_bus_matrix.v ----
// Two-master arbiter in front of the memory, control space and debug resources.
// Assumes core and debug requests are levels synchronous to clk.
`timescale 1ns/100ps
module lstu_bus_matrix (
   input wire clk,
   input wire reset_n,
   input wire core_req,
   input wire dbg_req,
   output reg core_grant_reg,
   output reg dbg_grant_reg
);
   // Fixed priority: debug only gets cycles the core leaves idle, so core timing never moves
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         core_grant_reg <= 1'b0;
         dbg_grant_reg <= 1'b0;
      end else begin
         core_grant_reg <= core_req;
         dbg_grant_reg <= dbg_req & ~core_req;
      end
   end
endmodule // lstu_bus_matrix

// ---- rtl/lstu_timing_unit.v ----
// Load/store issue timing: cycle cost per instruction, pipelining, stalls, store buffer.
// Assumes the core presents one instruction per issue_valid and honours the ready outputs.
`timescale 1ns/100ps
`include "lstu_defines.vh"
module lstu_timing_unit #(
   parameter CNT_W = 6
) (
   input wire clk,
   input wire reset_n,
   input wire issue_valid,
   input wire [2:0] issue_op,
   input wire issue_is_dp,
   input wire issue_is_store,
   input wire [3:0] issue_dest,
   input wire [3:0] issue_base,
   input wire [3:0] issue_index,
   input wire issue_uses_index,
   input wire issue_pc_rel,
   input wire issue_buffered,
   input wire [1:0] issue_size,
   input wire [1:0] issue_addr_lo,
   input wire [4:0] issue_elems,
   input wire issue_resume,
   input wire issue_resume_two,
   input wire sb_enable,
   input wire fetch_busy,
   input wire mem_ready,
   input wire dbg_req,
   output reg issue_ready_reg,
   output reg mem_issue_ready_reg,
   output reg busy_reg,
   output reg sb_full_reg,
   output reg [1:0] split_beats_reg,
   output wire core_grant_reg,
   output wire dbg_grant_reg
);
   reg [CNT_W-1:0] cnt_reg;
   reg [CNT_W-1:0] cnt_next;
   reg pipe_ok_reg;
   reg [3:0] load_dest_reg;
   reg dp_valid_reg;
   reg [3:0] dp_dest_reg;
   reg st_phase_reg;
   reg [CNT_W-1:0] cost;
   reg [1:0] beats;
   reg is_mem;
   reg is_single;
   reg dep_dp;
   reg dep_load;
   reg pipe_next;
   reg sb_usable;
   wire accept;
   wire mem_accept;
   wire sb_set;
   wire sb_full_next;
   wire ready_next;

   // True when a base or index register of the access matches a given register
   function addr_uses;
      input [3:0] base;
      input [3:0] index;
      input use_index;
      input [3:0] dest;
      begin
         addr_uses = (base == dest) | (use_index & (index == dest));
      end
   endfunction

   // Number of aligned pieces an access breaks into on the bus
   function [1:0] split_count;
      input [1:0] size;
      input [1:0] lo;
      begin
         if (size == `LSTU_SIZE_HALF && lo[0])
            split_count = 2'h2;
         else if (size == `LSTU_SIZE_WORD && lo == 2'h2)
            split_count = 2'h2;
         else if (size == `LSTU_SIZE_WORD && lo[0])
            split_count = 2'h3;
         else
            split_count = 2'h1;
      end
   endfunction

   // A memory op may only be taken when the buffer has nothing waiting to drain
   assign mem_accept = issue_valid & mem_issue_ready_reg & is_mem;
   assign accept = (issue_valid & issue_ready_reg & ~is_mem) | mem_accept;

   // Cost of the presented instruction
   always @* begin
      cost = `LSTU_CYC_LOAD;
      beats = 2'h1;
      is_mem = (issue_op != `LSTU_OP_OTHER);
      is_single = (issue_op == `LSTU_OP_LOAD) | (issue_op == `LSTU_OP_STORE) |
                  (issue_op == `LSTU_OP_LOAD_EXCL) | (issue_op == `LSTU_OP_STORE_EXCL);
      dep_dp = dp_valid_reg & addr_uses(issue_base, issue_index, issue_uses_index, dp_dest_reg);
      dep_load = addr_uses(issue_base, issue_index, issue_uses_index, load_dest_reg);
      pipe_next = 1'b0;
      sb_usable = sb_enable & ~sb_full_reg;
      case (issue_op)
         `LSTU_OP_LOAD, `LSTU_OP_LOAD_EXCL, `LSTU_OP_STORE_EXCL: begin
            // Exclusives pair exactly like a plain load_word
            if (issue_op == `LSTU_OP_LOAD && issue_dest == `LSTU_PC_REG) begin
               cost = `LSTU_CYC_LOAD_PC;
            end else begin
               cost = `LSTU_CYC_LOAD;
               pipe_next = 1'b1;
               if (pipe_ok_reg && !dep_load)
                  cost = cost - `LSTU_CYC_PIPE_SAVE;
               if (issue_pc_rel && fetch_busy)
                  cost = cost + `LSTU_CYC_FETCH;
            end
         end
         `LSTU_OP_STORE: begin
            // Nothing pipelines behind a store, so pipe_next stays low
            cost = issue_uses_index ? `LSTU_CYC_STORE_REG : `LSTU_CYC_STORE_IMM;
            if (issue_uses_index && pipe_ok_reg && !dep_load)
               cost = cost - `LSTU_CYC_PIPE_SAVE;
         end
         `LSTU_OP_PAIR: begin
            cost = `LSTU_CYC_PAIR;
         end
         `LSTU_OP_MULTIPLE: begin
            cost = {{(CNT_W-5){1'b0}}, issue_elems} + `LSTU_CYC_MULT_FIRST;
            if (issue_resume)
               cost = cost + (issue_resume_two ? 6'h02 : 6'h01);
         end
         `LSTU_OP_TABLE_BR: begin
            cost = `LSTU_CYC_TABLE_BR;
         end
         default: begin
            cost = 6'h01;
         end
      endcase
      if (is_mem && dep_dp)
         cost = cost + `LSTU_CYC_DEP;
      if (is_single) begin
         beats = split_count(issue_size, issue_addr_lo);
         cost = cost + {{(CNT_W-2){1'b0}}, beats} - 6'h01;
      end
   end

   // Remaining-cycle counter; memory stalls freeze it so waits stretch every multi-cycle cost
   always @* begin
      cnt_next = cnt_reg;
      if (accept) begin
         if (issue_op == `LSTU_OP_STORE && issue_buffered && sb_usable && !issue_uses_index)
            cnt_next = cost - 6'h01; // Buffered store retires now, bus catches up later
         else if (issue_op == `LSTU_OP_STORE && issue_buffered && !sb_usable)
            cnt_next = (cost > 6'h01) ? cost - 6'h01 : 6'h01; // Must wait for the bus itself
         else
            cnt_next = cost - 6'h01;
      end else if (cnt_reg != {CNT_W{1'b0}} && mem_ready && !fetch_busy) begin
         cnt_next = cnt_reg - 6'h01;
      end else if (cnt_reg != {CNT_W{1'b0}} && mem_ready && !busy_reg) begin
         cnt_next = cnt_reg - 6'h01;
      end
   end

   // Buffer fills only if the bus waits in the buffered store's data phase
   assign sb_set = st_phase_reg & ~mem_ready;
   // Set and drain never meet in one cycle: the set needs a wait, the drain a ready cycle
   assign sb_full_next = sb_set | (sb_full_reg & ~mem_ready);
   assign ready_next = (cnt_next == {CNT_W{1'b0}});

   // Issue state, history of the previous instruction and buffer occupancy
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= {CNT_W{1'b0}};
         pipe_ok_reg <= 1'b0;
         load_dest_reg <= 4'h0;
         dp_valid_reg <= 1'b0;
         dp_dest_reg <= 4'h0;
         st_phase_reg <= 1'b0;
         sb_full_reg <= 1'b0;
         issue_ready_reg <= 1'b0;
         mem_issue_ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         split_beats_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_next;
         sb_full_reg <= sb_full_next;
         issue_ready_reg <= ready_next;
         mem_issue_ready_reg <= ready_next & ~sb_full_next;
         busy_reg <= ~ready_next;
         st_phase_reg <= accept & (issue_op == `LSTU_OP_STORE) & issue_buffered & sb_usable;
         if (accept) begin
            pipe_ok_reg <= pipe_next;
            load_dest_reg <= issue_dest;
            dp_valid_reg <= issue_is_dp & ~is_mem;
            dp_dest_reg <= issue_dest;
            split_beats_reg <= is_single ? beats : 2'h0;
         end
      end
   end

   // Core wants the bus when a memory op is taken, while busy with a memory op presented on issue_op, or while the buffer drains
   lstu_bus_matrix u_matrix (
      .clk(clk),
      .reset_n(reset_n),
      .core_req(mem_accept | (busy_reg & is_mem) | sb_full_reg | st_phase_reg),
      .dbg_req(dbg_req),
      .core_grant_reg(core_grant_reg),
      .dbg_grant_reg(dbg_grant_reg)
   );
endmodule // lstu_timing_unit

// ---- verif/lstu_timing_sva.sv ----
// Checker for the load/store issue timing unit, watching its ports only.
// Assumes one clock and the asynchronous active-low reset of the unit.
`timescale 1ns/100ps
`include "lstu_defines.vh"
module lstu_timing_sva (
   input wire clk,
   input wire reset_n,
   input wire issue_valid,
   input wire [2:0] issue_op,
   input wire [3:0] issue_dest,
   input wire issue_buffered,
   input wire [1:0] issue_size,
   input wire [1:0] issue_addr_lo,
   input wire [4:0] issue_elems,
   input wire sb_enable,
   input wire mem_ready,
   input wire dbg_req,
   input wire issue_ready_reg,
   input wire mem_issue_ready_reg,
   input wire sb_full_reg,
   input wire [1:0] split_beats_reg,
   input wire core_grant_reg,
   input wire dbg_grant_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Memory-class instruction taken at this edge
   wire mem_acc = issue_valid && mem_issue_ready_reg && issue_op != `LSTU_OP_OTHER;
   pc_load_a: assert property (
      mem_acc && issue_op == `LSTU_OP_LOAD && issue_dest == `LSTU_PC_REG |=> !issue_ready_reg [*4])
      else $error("program counter load released early");
   table_branch_a: assert property (
      mem_acc && issue_op == `LSTU_OP_TABLE_BR |=> !issue_ready_reg [*5])
      else $error("table branch released early");
   pair_cost_a: assert property (
      mem_acc && issue_op == `LSTU_OP_PAIR |=> !issue_ready_reg [*2])
      else $error("pair released early");
   multiple_cost_a: assert property (
      mem_acc && issue_op == `LSTU_OP_MULTIPLE && issue_elems == 5'h03 |=> !issue_ready_reg [*3])
      else $error("multiple released early");
   split_three_a: assert property (
      mem_acc && issue_op == `LSTU_OP_LOAD && issue_size == `LSTU_SIZE_WORD && issue_addr_lo == 2'h1
      |=> split_beats_reg == 2'h3) else $error("byte aligned word not three pieces");
   buffer_fill_a: assert property (
      mem_acc && issue_op == `LSTU_OP_STORE && issue_buffered && sb_enable ##1 !mem_ready |=> sb_full_reg)
      else $error("waited store not buffered");
   buffer_cause_a: assert property (
      $rose(sb_full_reg) |-> !$past(mem_ready)) else $error("buffer filled without wait");
   buffer_hold_a: assert property (
      sb_full_reg && !mem_ready |=> sb_full_reg && !mem_issue_ready_reg)
      else $error("access passed a full buffer");
   core_first_a: assert property (
      sb_full_reg |=> core_grant_reg && !dbg_grant_reg) else $error("debug granted over core");
   debug_cause_a: assert property (
      dbg_grant_reg |-> $past(dbg_req)) else $error("debug granted unasked");
endmodule // lstu_timing_sva
bind lstu_timing_unit lstu_timing_sva chk (.*);

// ---- verif/lstu_mem_model.sv ----
// Memory side partner: data-phase wait states on request, bursts of debug traffic.
// Assumes the bench raises stall_go during the access it wants the bus to wait.
`timescale 1ns/100ps
module lstu_mem_model (
   input wire clk,
   input wire reset_n,
   input wire stall_go,
   input wire [3:0] waits,
   input wire dbg_on,
   output logic mem_ready,
   output logic dbg_req
);
   logic [3:0] wait_reg;
   logic [2:0] dbg_reg;
   // Wait counter reloads from waits on each marked cycle, so each new mark restarts the hold
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 4'h0;
         dbg_reg <= 3'h0;
      end else begin
         wait_reg <= stall_go ? waits : wait_reg - {3'h0, wait_reg != 4'h0};
         dbg_reg <= dbg_reg + 3'h1;
      end
   end
   assign mem_ready = wait_reg == 4'h0;
   // Debug asks in two-cycle bursts to hit both grant and refusal
   assign dbg_req = dbg_on && dbg_reg[1];
endmodule // lstu_mem_model

// ---- verif/load_store_timing_unit_test.sv ----
// Bench for the load/store timing unit: issue streams scored against a cost model.
// Assumes the memory partner model and the bound checker.
`timescale 1ns/100ps
module load_store_timing_unit_test;
   logic clk = 0, reset_n = 0, v = 0, ui = 0, pr = 0, bf = 0, rs = 0, r2 = 0, sbe = 1, fb = 0, go = 0, dbg_on = 0;
   logic [2:0] op = 3'h0;
   logic [3:0] de = 4'h0, ba = 4'h0, ix = 4'h0, wt = 4'h3;
   logic [1:0] sz = 2'h2, lo = 2'h0;
   logic [4:0] el = 5'h1;
   logic [31:0] seed = 32'h3115f7ab;
   wire ir, mir, mr, dq, sf, bs;
   wire [1:0] sp;
   int error_cnt = 0, checks = 0, prev = 0, pdest = 0, pend = -1, k;
   always #50 clk = ~clk;
   lstu_timing_unit dut (.clk(clk), .reset_n(reset_n), .issue_valid(v), .issue_op(op), .issue_is_dp(op == 3'h0),
      .issue_is_store(op == 3'h2 || op == 3'h4), .issue_dest(de), .issue_base(ba), .issue_index(ix),
      .issue_uses_index(ui), .issue_pc_rel(pr), .issue_buffered(bf), .issue_size(sz), .issue_addr_lo(lo),
      .issue_elems(el), .issue_resume(rs), .issue_resume_two(r2), .sb_enable(sbe), .fetch_busy(fb),
      .mem_ready(mr), .dbg_req(dq), .issue_ready_reg(ir), .mem_issue_ready_reg(mir), .busy_reg(bs),
      .sb_full_reg(sf), .split_beats_reg(sp), .core_grant_reg(), .dbg_grant_reg());
   lstu_mem_model mem (.clk(clk), .reset_n(reset_n), .stall_go(go), .waits(wt), .dbg_on(dbg_on),
      .mem_ready(mr), .dbg_req(dq));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Expected cycles of the presented instruction given the one before it
   function automatic int cost();
      int c;
      logic dep;
      dep = ba == pdest || (ui && ix == pdest);
      case (op)
         3'h0: c = 1;
         3'h2: c = bf && !sbe ? 2 + (go ? wt : 0) : (ui ? 2 : 1);
         3'h5: c = 3;
         3'h6: c = el + 1 + (rs ? (r2 ? 2 : 1) : 0);
         3'h7: c = 6;
         default: c = op == 3'h1 && de == 4'hf ? 5 : 2;
      endcase
      if (prev == 1 && op != 3'h0 && op < 3'h5 && !dep && c == 2)
         c = 1;
      if (prev == 2 && op != 3'h0 && dep)
         c++;
      if (op == 3'h1 && pr && fb)
         c++;
      if (op == 3'h1 || op == 3'h2)
         c += sz == 2'h1 ? lo[0] : (lo == 2'h0 ? 0 : (lo[0] ? 2 : 1));
      return c;
   endfunction
   // Hold one instruction until taken; the gap since the last one scores that one's cost
   task automatic issue(input logic [2:0] o, input logic [3:0] d, b, input logic u);
      int e;
      int pc;
      logic t;
      op = o;
      de = d;
      ba = b;
      ix = b + 4'h1;
      ui = u;
      v = 1;
      e = cost();
      k = 0;
      do begin
         t = o == 3'h0 ? ir : mir;
         @(posedge clk);
         #1;
         k++;
      end while (t !== 1'b1 && k < 60);
      if (t !== 1'b1) begin
         error_cnt++;
         report_and_stop();
      end
      if (pend >= 0)
         check("issue gap", k, pend);
      // Pieces of a single access follow size and low address bits; others report none
      pc = (o == 3'h0 || o > 3'h4) ? 0 : sz == 2'h1 ? 1 + lo[0] : sz == 2'h2 ? (lo == 2'h0 ? 1 : (lo[0] ? 3 : 2)) : 1;
      check("split pieces", sp, pc);
      check("busy after issue", bs, e > 1);
      pend = e;
      prev = o == 3'h0 ? 2 : (o == 3'h3 || o == 3'h4 || (o == 3'h1 && d != 4'hf)) ? 1 : 0;
      pdest = d;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1;
      @(posedge clk);
      #1;
      // Dependency, pipelining, blocking and split accesses back to back
      issue(3'h0, 4'h1, 4'h0, 0);
      issue(3'h1, 4'h3, 4'h1, 0);
      issue(3'h1, 4'h5, 4'h2, 1);
      issue(3'h2, 4'h6, 4'h7, 1);
      issue(3'h1, 4'hf, 4'h2, 0);
      issue(3'h7, 4'h0, 4'h8, 0);
      sz = 2'h1;
      lo = 2'h1;
      issue(3'h1, 4'h3, 4'h9, 0);
      sz = 2'h2;
      issue(3'h5, 4'h0, 4'h8, 0);
      issue(3'h1, 4'h4, 4'h9, 0);
      lo = 2'h2;
      el = 5'h3;
      issue(3'h6, 4'h0, 4'h8, 0);
      issue(3'h2, 4'h4, 4'h9, 0);
      lo = 2'h0;
      el = 5'h8;
      rs = 1;
      r2 = 1;
      issue(3'h6, 4'h0, 4'h8, 0);
      rs = 0;
      r2 = 0;
      issue(3'h0, 4'hc, 4'h0, 0);
      pr = 1;
      fb = 1;
      issue(3'h1, 4'h2, 4'hf, 0);
      pr = 0;
      fb = 0;
      // Buffered store waited by the bus, then the same store with the buffer off
      issue(3'h0, 4'hc, 4'h0, 0);
      bf = 1;
      go = 1;
      issue(3'h2, 4'h1, 4'h2, 0);
      go = 0;
      issue(3'h0, 4'hd, 4'h0, 0);
      check("buffer full", sf, 1);
      check("memory issue ready", mir, 0);
      v = 0;
      pend = -1;
      k = 0;
      while (mir !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      check("buffer drained", k < 5, 1);
      sbe = 0;
      issue(3'h0, 4'hc, 4'h0, 0);
      go = 1;
      issue(3'h2, 4'h1, 4'h2, 0);
      go = 0;
      bf = 0;
      issue(3'h0, 4'hc, 4'h0, 0);
      sbe = 1;
      // Random stream with debug traffic, zero-wait memory, aligned word transfers only
      // Portable code keeps to word-sized aligned accesses
      dbg_on = 1;
      repeat (150) begin
         el = 5'(1 + rnd() % 8);
         issue(3'(rnd() % 7), 4'(rnd() % 15), 4'(rnd()), 1'(rnd()));
      end
      issue(3'h0, 4'hc, 4'h0, 0);
      report_and_stop();
   end
endmodule // load_store_timing_unit_test
